// >>> ahbt_pkg.sv
// Package for the acknowledgment handling and base timer block.
// Assumes a 40 MHz core clock and an APB register bus with 32-bit data.
package ahbt_pkg;
  // Register byte addresses
  localparam logic [7:0] AHBT_TMR_CTRL_OFS  = 8'h00;
  localparam logic [7:0] AHBT_RX_CTRL_OFS   = 8'h04;
  localparam logic [7:0] AHBT_TIMERS_OFS    = 8'h08;
  localparam logic [7:0] AHBT_TIMERS2_OFS   = 8'h0C;
  localparam logic [7:0] AHBT_RETRY_OFS     = 8'h10;
  localparam logic [7:0] AHBT_FLAGS_OFS     = 8'h14;
  localparam logic [7:0] AHBT_CMD_OFS       = 8'h18;
  // Field positions and reset values
  localparam int         AHBT_BASE_W        = 5;
  localparam logic [4:0] AHBT_BASE_RST      = 5'h02;
  localparam int         AHBT_RXC_FULL      = 0;
  localparam int         AHBT_RXC_DUPREJ    = 1;
  localparam int         AHBT_RXC_AUTO_ACK_SETTING   = 2;
  localparam int         AHBT_RXC_RECEIVE_ENABLE      = 3;
  localparam int         AHBT_CMD_TRANSMIT_START      = 0;
  // Flag bit positions
  localparam int         AHBT_F_TXDONE      = 0;
  localparam int         AHBT_F_TXSFD       = 1;
  localparam int         AHBT_F_TXMA        = 2;
  localparam int         AHBT_F_RXOVF       = 3;
  localparam int         AHBT_F_DUP         = 4;
  localparam int         AHBT_F_RXSFD       = 5;
  localparam int         AHBT_F_RXDONE      = 6;
  localparam int         AHBT_F_ACKFAIL     = 7;
  localparam int         AHBT_NFLAGS        = 8;
  // Timing
  localparam int         AHBT_CLK_MHZ       = 40;
  localparam int         AHBT_US_CYC        = AHBT_CLK_MHZ;
  localparam int         AHBT_MAX_DELAY_MS  = 131;
  localparam int         AHBT_MAX_DELAY_US  = AHBT_MAX_DELAY_MS * 1000;
  localparam int         AHBT_OFF_SHIFT     = 5;
  typedef enum logic [2:0] {
    AHBT_IDLE,
    AHBT_ACK_TURN,
    AHBT_ACK_SEND,
    AHBT_TX_SEND,
    AHBT_ACK_WAIT
  } ahbt_state_t;
endpackage

// >>> ahbt_tick.sv
// Base time unit tick generator.
// Assumes one clock; base_sel is held steady while the radio is active.
`timescale 1ns/1ps
`default_nettype none
module ahbt_tick
  import ahbt_pkg::*;
#(
  parameter int US_CYC = AHBT_US_CYC
)(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [AHBT_BASE_W-1:0] base_sel_i,
  output logic                        us_tick_o,
  output logic                        base_tick_o
);
  logic [7:0]             pre_r,  pre_nxt;
  logic [AHBT_BASE_W-1:0] us_r,   us_nxt;
  logic                   ust_nxt, bt_nxt;

  // One-microsecond prescaler, then divide by base select
  always_comb
  begin
    pre_nxt = pre_r + 8'h01;
    ust_nxt = 1'b0;
    us_nxt  = us_r;
    bt_nxt  = 1'b0;
    if (pre_r == 8'(US_CYC - 1))
    begin
      pre_nxt = 8'h00;
      ust_nxt = 1'b1;
      us_nxt  = us_r + 5'h01;
      // Zero select treated as one microsecond to keep time moving
      if (us_r + 5'h01 >= base_sel_i)                               // R12 R21
      begin
        us_nxt = 5'h00;
        bt_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_r       <= 8'h00;
      us_r        <= 5'h00;
      us_tick_o   <= 1'b0;
      base_tick_o <= 1'b0;
    end
    else
    begin
      pre_r       <= pre_nxt;
      us_r        <= us_nxt;
      us_tick_o   <= ust_nxt;
      base_tick_o <= bt_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> ahbt_core.sv
// Acknowledgment handling and base time unit timers with an APB slave.
// Assumes frame events from a parser as one-cycle pulses on the core clock.
// Contract
// R1: Acknowledgments go out with no backoff or channel assessment.
// R2: Finished ACK sets tx sfd and medium access flags, not tx done.
// R3: Empty buffer, no dup reject: accept frame, buffer full, ACK only if asked.
// R4: Empty buffer, auto ack and ack request: send ACK, set buffer full.
// R5: Empty buffer with dup reject: store sequence and source for comparison.
// R6: Full buffer, no dup reject: no ACK, set overflow flag.
// R7: Full, dup reject, not both ack bits: no ACK; duplicate or overflow flag.
// R8: Full, dup reject, both ack bits: match sends ACK and duplicate flag.
// R9: Valid ACK has matching sequence; raises rx sfd and tx done.
// R10: Receiving an ACK never raises rx done.
// R11: Retry count at or above limit without valid ACK raises ack failure.
// R12: Base time unit equals base select microseconds.
// R13: Turnaround, ack wait, backoff and stream timers count base units.
// R14: Host keeps base select steady while receiving or transmitting.
// R15: Minimum off time counts in units of 32 base units.
// R16: Wait turnaround delay base units before transmitting the ACK.
// R17: Look for ACK at most ack wait timeout, then retry or fail.
// R18: Any timer delay is clamped to 131 ms.
// R19: Host should use 160 units at 2 us or 80 at 4 us for backoff.
// R20: Base select in low five bits of timer control, reset 00010.
// R21: Base tick comes from a 1 us prescaler divided by base select.
`timescale 1ns/1ps
`default_nettype none
module ahbt_core
  import ahbt_pkg::*;
#(
  parameter int SEQ_W = 8,
  parameter int SRC_W = 80
)(
  input  wire logic             CORE_CLK_I,
  input  wire logic             SYS_RST_I,
  input  wire logic             PSEL_I,
  input  wire logic             PENABLE_I,
  input  wire logic             PWRITE_I,
  input  wire logic [7:0]       PADDR_I,
  input  wire logic [31:0]      PWDATA_I,
  output logic      [31:0]      PRDATA_O,
  output logic                  PREADY_O,
  output logic                  PSLVERR_O,
  input  wire logic             RX_FRAME_I,
  input  wire logic             RX_IS_ACK_I,
  input  wire logic             RX_ACK_REQ_I,
  input  wire logic [SEQ_W-1:0] RX_SEQ_I,
  input  wire logic [SRC_W-1:0] RX_SRC_I,
  input  wire logic [SEQ_W-1:0] TX_SEQ_I,
  input  wire logic             TX_FRAME_DONE_I,
  output logic                  TX_ACK_START_O,
  output logic                  TX_FRAME_START_O,
  output logic                  TX_CCA_BYPASS_O,
  output logic                  BACKOFF_TICK_O,
  output logic                  STREAM_TO_O,
  output logic                  OFF_TIME_DONE_O
);
  logic [4:0]        base_r,    base_nxt;
  logic [3:0]        rxc_r,     rxc_nxt;
  logic [7:0]        turn_r,    turn_nxt;
  logic [7:0]        ackto_r,   ackto_nxt;
  logic [7:0]        backoff_period_units_r,  backoff_period_units_nxt;
  logic [15:0]       strm_r,    strm_nxt;
  logic [7:0]        min_off_time_r,   min_off_time_nxt;
  logic [3:0]        rlim_r,    rlim_nxt;
  logic [3:0]        rcnt_r,    rcnt_nxt;
  logic [7:0]        flag_r,    flag_nxt;
  logic [SEQ_W-1:0]  sseq_r,    sseq_nxt;
  logic [SRC_W-1:0]  ssrc_r,    ssrc_nxt;
  logic [19:0]       tmr_r,     tmr_nxt;
  logic [7:0]        bo_r,      bo_nxt;
  logic [15:0]       st_r,      st_nxt;
  logic [12:0]       off_r,     off_nxt;
  ahbt_state_t       st_q,      st_d;
  logic              transmit_start_r,    transmit_start_nxt;
  logic              acks_nxt,  frs_nxt,   bot_nxt;
  logic              sto_nxt,   offd_nxt;
  logic [31:0]       rd_nxt;
  logic              us_tick,   base_tick;
  logic              wr,        rd;
  logic              match;
  logic [7:0]        fset;

  // Clamp a base-unit count so that count times base stays within 131 ms
  function automatic logic [19:0] clamp_units(input logic [19:0] n,
                                              input logic [4:0]  b);
    logic [19:0] lim;
    lim = (b == 5'h00) ? 20'(AHBT_MAX_DELAY_US)
                       : 20'(AHBT_MAX_DELAY_US) / {15'h0000, b};
    clamp_units = (n > lim) ? lim : n;                              // R18
  endfunction

  ahbt_tick u_tick (
    .clk_i       (CORE_CLK_I),
    .rst_i       (SYS_RST_I),
    .base_sel_i  (base_r),
    .us_tick_o   (us_tick),
    .base_tick_o (base_tick)
  );

  assign wr    = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd    = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign match = (sseq_r == RX_SEQ_I) && (ssrc_r == RX_SRC_I);

  // Register writes; flags are write-one-to-clear and a set beats a clear
  always_comb
  begin
    base_nxt   = base_r;
    rxc_nxt    = rxc_r;
    turn_nxt   = turn_r;
    ackto_nxt  = ackto_r;
    backoff_period_units_nxt = backoff_period_units_r;
    strm_nxt   = strm_r;
    min_off_time_nxt  = min_off_time_r;
    rlim_nxt   = rlim_r;
    transmit_start_nxt   = transmit_start_r;
    flag_nxt   = flag_r;
    if (wr)
    begin
      unique case (PADDR_I)
        AHBT_TMR_CTRL_OFS: base_nxt = PWDATA_I[4:0];                // R20
        AHBT_RX_CTRL_OFS:  rxc_nxt  = PWDATA_I[3:0];
        AHBT_TIMERS_OFS:
        begin
          turn_nxt   = PWDATA_I[7:0];
          ackto_nxt  = PWDATA_I[15:8];
          backoff_period_units_nxt = PWDATA_I[23:16];
          min_off_time_nxt  = PWDATA_I[31:24];
        end
        AHBT_TIMERS2_OFS:  strm_nxt = PWDATA_I[15:0];
        AHBT_RETRY_OFS:    rlim_nxt = PWDATA_I[3:0];
        AHBT_FLAGS_OFS:    flag_nxt = flag_r & ~PWDATA_I[7:0];
        AHBT_CMD_OFS:      transmit_start_nxt = PWDATA_I[AHBT_CMD_TRANSMIT_START];
        default:           base_nxt = base_r;
      endcase
    end
    flag_nxt = flag_nxt | fset;
    if (fset[AHBT_F_ACKFAIL] || fset[AHBT_F_TXDONE])
      transmit_start_nxt = 1'b0;
    // Hardware setting of the buffer-full bit on accepted frames
    if (RX_FRAME_I && !RX_IS_ACK_I && !rxc_r[AHBT_RXC_FULL])
      rxc_nxt[AHBT_RXC_FULL] = 1'b1;                                // R3 R4
  end

  // Read mux; unmapped reads give zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    unique case (PADDR_I)
      AHBT_TMR_CTRL_OFS: rd_nxt = {27'h0000000, base_r};
      AHBT_RX_CTRL_OFS:  rd_nxt = {28'h0000000, rxc_r};
      AHBT_TIMERS_OFS:   rd_nxt = {min_off_time_r, backoff_period_units_r, ackto_r, turn_r};
      AHBT_TIMERS2_OFS:  rd_nxt = {16'h0000, strm_r};
      AHBT_RETRY_OFS:    rd_nxt = {24'h000000, rcnt_r, rlim_r};
      AHBT_FLAGS_OFS:    rd_nxt = {24'h000000, flag_r};
      AHBT_CMD_OFS:      rd_nxt = {31'h00000000, transmit_start_r};
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end

  // Acknowledgment sequencing, frame decisions and retry control
  always_comb
  begin
    st_d     = st_q;
    tmr_nxt  = tmr_r;
    rcnt_nxt = rcnt_r;
    sseq_nxt = sseq_r;
    ssrc_nxt = ssrc_r;
    fset     = 8'h00;
    acks_nxt = 1'b0;
    frs_nxt  = 1'b0;
    if (RX_FRAME_I && !RX_IS_ACK_I && st_q != AHBT_ACK_WAIT)
    begin
      if (!rxc_r[AHBT_RXC_FULL])
      begin
        if (rxc_r[AHBT_RXC_DUPREJ])
        begin
          sseq_nxt = RX_SEQ_I;                                      // R5
          ssrc_nxt = RX_SRC_I;
        end
        if (rxc_r[AHBT_RXC_AUTO_ACK_SETTING] && RX_ACK_REQ_I)                // R3 R4
        begin
          st_d    = AHBT_ACK_TURN;
          tmr_nxt = clamp_units({12'h000, turn_r}, base_r);
        end
      end
      else if (!rxc_r[AHBT_RXC_DUPREJ])
        fset[AHBT_F_RXOVF] = 1'b1;                                  // R6
      else if (!match)
        fset[AHBT_F_RXOVF] = 1'b1;                                  // R7 R8
      else
      begin
        fset[AHBT_F_DUP] = 1'b1;                                    // R7 R8
        if (rxc_r[AHBT_RXC_AUTO_ACK_SETTING] && RX_ACK_REQ_I)                // R8
        begin
          st_d    = AHBT_ACK_TURN;
          tmr_nxt = clamp_units({12'h000, turn_r}, base_r);
        end
      end
      if (!(rxc_r[AHBT_RXC_FULL]))
        fset[AHBT_F_RXDONE] = 1'b1;
    end
    unique case (st_q)
      AHBT_IDLE:
        if (transmit_start_r && !(RX_FRAME_I && !RX_IS_ACK_I))
        begin
          st_d    = AHBT_TX_SEND;
          frs_nxt = 1'b1;
        end
      AHBT_ACK_TURN:
        if (tmr_r == 20'h00000)                                     // R16
        begin
          st_d     = AHBT_ACK_SEND;
          acks_nxt = 1'b1;                                          // R1
        end
        else if (base_tick)
          tmr_nxt = tmr_r - 20'h00001;                              // R13
      AHBT_ACK_SEND:
        if (TX_FRAME_DONE_I)
        begin
          st_d = AHBT_IDLE;
          fset[AHBT_F_TXSFD] = 1'b1;                                // R2
          fset[AHBT_F_TXMA]  = 1'b1;                                // R2
        end
      AHBT_TX_SEND:
        if (TX_FRAME_DONE_I)
        begin
          fset[AHBT_F_TXSFD] = 1'b1;
          fset[AHBT_F_TXMA]  = 1'b1;
          if (rxc_r[AHBT_RXC_AUTO_ACK_SETTING])
          begin
            st_d    = AHBT_ACK_WAIT;
            tmr_nxt = clamp_units({12'h000, ackto_r}, base_r);
          end
          else
          begin
            st_d = AHBT_IDLE;
            fset[AHBT_F_TXDONE] = 1'b1;
          end
        end
      AHBT_ACK_WAIT:
        if (RX_FRAME_I && RX_IS_ACK_I && RX_SEQ_I == TX_SEQ_I)     // R9 R10
        begin
          st_d     = AHBT_IDLE;
          rcnt_nxt = 4'h0;
          fset[AHBT_F_RXSFD]  = 1'b1;                               // R9
          fset[AHBT_F_TXDONE] = 1'b1;                               // R9
        end
        else if (tmr_r == 20'h00000)                                // R17
        begin
          if (rcnt_r >= rlim_r)                                     // R11
          begin
            st_d     = AHBT_IDLE;
            rcnt_nxt = 4'h0;
            fset[AHBT_F_ACKFAIL] = 1'b1;
          end
          else
          begin
            st_d     = AHBT_TX_SEND;
            rcnt_nxt = rcnt_r + 4'h1;
            frs_nxt  = 1'b1;
          end
        end
        else if (base_tick)
          tmr_nxt = tmr_r - 20'h00001;                              // R13
      default: st_d = AHBT_IDLE;
    endcase
    if (!transmit_start_r && (st_q == AHBT_TX_SEND || st_q == AHBT_ACK_WAIT))
      st_d = AHBT_IDLE;
  end

  // Backoff period, stream timeout and off-time timers on the base tick
  always_comb
  begin
    bo_nxt   = bo_r;
    st_nxt   = st_r;
    off_nxt  = off_r;
    bot_nxt  = 1'b0;
    sto_nxt  = 1'b0;
    offd_nxt = 1'b0;
    if (base_tick)
    begin
      bo_nxt = bo_r + 8'h01;
      if (bo_r == backoff_period_units_r)                                         // R13
      begin
        bo_nxt  = 8'h00;
        bot_nxt = 1'b1;
      end
      if (RX_FRAME_I || !rxc_r[AHBT_RXC_RECEIVE_ENABLE])
        st_nxt = 16'h0000;
      else if (20'(st_r) + 20'h00001 >= clamp_units(20'(strm_r), base_r))
      begin
        st_nxt  = 16'h0000;                                         // R18
        sto_nxt = strm_r != 16'h0000;
      end
      else
        st_nxt = st_r + 16'h0001;
      if (off_r != 13'h0000)
      begin
        off_nxt  = off_r - 13'h0001;                                // R15
        offd_nxt = off_r == 13'h0001;
      end
    end
    if (TX_FRAME_DONE_I)
      off_nxt = 13'(clamp_units(20'(min_off_time_r) << AHBT_OFF_SHIFT,
                                base_r));                           // R15 R18
    // A frame between base ticks must still restart the stream timeout
    if (RX_FRAME_I || !rxc_r[AHBT_RXC_RECEIVE_ENABLE])
    begin
      st_nxt  = 16'h0000;
      sto_nxt = 1'b0;
    end
  end

  // Register all state and outputs
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      base_r           <= AHBT_BASE_RST;                            // R20
      rxc_r            <= 4'h0;
      turn_r           <= 8'h00;
      ackto_r          <= 8'h00;
      backoff_period_units_r         <= 8'h00;
      strm_r           <= 16'h0000;
      min_off_time_r          <= 8'h00;
      rlim_r           <= 4'h0;
      rcnt_r           <= 4'h0;
      flag_r           <= 8'h00;
      sseq_r           <= '0;
      ssrc_r           <= '0;
      tmr_r            <= 20'h00000;
      bo_r             <= 8'h00;
      st_r             <= 16'h0000;
      off_r            <= 13'h0000;
      st_q             <= AHBT_IDLE;
      transmit_start_r           <= 1'b0;
      PRDATA_O         <= 32'h0000_0000;
      PREADY_O         <= 1'b0;
      PSLVERR_O        <= 1'b0;
      TX_ACK_START_O   <= 1'b0;
      TX_FRAME_START_O <= 1'b0;
      TX_CCA_BYPASS_O  <= 1'b0;
      BACKOFF_TICK_O   <= 1'b0;
      STREAM_TO_O      <= 1'b0;
      OFF_TIME_DONE_O  <= 1'b0;
    end
    else
    begin
      base_r           <= base_nxt;
      rxc_r            <= rxc_nxt;
      turn_r           <= turn_nxt;
      ackto_r          <= ackto_nxt;
      backoff_period_units_r         <= backoff_period_units_nxt;
      strm_r           <= strm_nxt;
      min_off_time_r          <= min_off_time_nxt;
      rlim_r           <= rlim_nxt;
      rcnt_r           <= rcnt_nxt;
      flag_r           <= flag_nxt;
      sseq_r           <= sseq_nxt;
      ssrc_r           <= ssrc_nxt;
      tmr_r            <= tmr_nxt;
      bo_r             <= bo_nxt;
      st_r             <= st_nxt;
      off_r            <= off_nxt;
      st_q             <= st_d;
      transmit_start_r           <= transmit_start_nxt;
      if (rd)
        PRDATA_O <= rd_nxt;
      PREADY_O         <= PSEL_I && !PENABLE_I;
      PSLVERR_O        <= 1'b0;
      TX_ACK_START_O   <= acks_nxt;
      TX_FRAME_START_O <= frs_nxt;
      TX_CCA_BYPASS_O  <= acks_nxt || st_d == AHBT_ACK_SEND;        // R1
      BACKOFF_TICK_O   <= bot_nxt;
      STREAM_TO_O      <= sto_nxt;
      OFF_TIME_DONE_O  <= offd_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> ahbt_asserts.sv
// Checker on the ports of the ack handling and base timer core.
// Assumes one clock and the active-high synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ahbt_asserts
  import ahbt_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        TX_FRAME_DONE_I,
  input wire logic        TX_ACK_START_O,
  input wire logic        TX_FRAME_START_O,
  input wire logic        TX_CCA_BYPASS_O,
  input wire logic        BACKOFF_TICK_O
);
  logic [23:0] gap_r;
  logic [23:0] gap_nxt;
  logic        seen_r;
  logic        seen_nxt;
  logic        rd_end;
  logic        start;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Gap between backoff ticks; the first tick only arms the check
  always_comb
  begin
    gap_nxt  = BACKOFF_TICK_O ? 24'h1 : gap_r + 24'h1;
    seen_nxt = seen_r | BACKOFF_TICK_O;
  end
  always_ff @(posedge CORE_CLK_I)
  begin
    gap_r  <= SYS_RST_I ? 24'h0 : gap_nxt;
    seen_r <= SYS_RST_I ? 1'b0 : seen_nxt;
  end
  // Read completion and any transmit start
  assign rd_end = PREADY_O && !PWRITE_I;
  assign start  = TX_ACK_START_O || TX_FRAME_START_O;
  ready_timing_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("Ready missing in access cycle");
  ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && !PENABLE_I))
    else $error("Ready without setup cycle");
  hole_zero_a: assert property (
    rd_end && PADDR_I >= 8'h1C |-> PRDATA_O == 32'h0)
    else $error("Unmapped read not zero");
  base_field_a: assert property (
    rd_end && PADDR_I == AHBT_TMR_CTRL_OFS |-> PRDATA_O[31:5] == 27'h0)
    else $error("Base select wider than five bits");
  ack_no_cca_a: assert property (
    TX_ACK_START_O |-> ##[0:1] TX_CCA_BYPASS_O)
    else $error("ACK started with channel access");
  cca_release_a: assert property (
    TX_CCA_BYPASS_O && TX_FRAME_DONE_I |-> ##[1:2] !TX_CCA_BYPASS_O)
    else $error("Bypass held after ACK done");
  data_cca_a: assert property (TX_FRAME_START_O |-> !TX_CCA_BYPASS_O)
    else $error("Data frame skips channel access");
  start_pulse_a: assert property (start |=> !start)
    else $error("Start longer than one cycle");
  no_error_a: assert property (PREADY_O |-> !PSLVERR_O)
    else $error("Slave error on a transfer");
  tick_grid_a: assert property (
    BACKOFF_TICK_O && seen_r |-> gap_r % AHBT_US_CYC == 0)
    else $error("Backoff tick off the microsecond grid");
  ack_seen_c: cover property (TX_ACK_START_O);
  frame_seen_c: cover property (TX_FRAME_START_O);
  tick_seen_c: cover property (BACKOFF_TICK_O && seen_r);
endmodule
bind ahbt_core ahbt_asserts ahbt_asserts_inst (
  .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .TX_FRAME_DONE_I(TX_FRAME_DONE_I), .TX_ACK_START_O(TX_ACK_START_O),
  .TX_FRAME_START_O(TX_FRAME_START_O), .TX_CCA_BYPASS_O(TX_CCA_BYPASS_O),
  .BACKOFF_TICK_O(BACKOFF_TICK_O));
`default_nettype wire

// >>> ahbt_peer.sv
// Peer radio node: hands parsed frames in and paces each transmission.
// Assumes one-cycle start pulses on the shared core clock.
`timescale 1ns/1ps
`default_nettype none
module ahbt_peer
(
  input  wire logic        clk_i,
  input  wire logic        ack_start_i,
  input  wire logic        frame_start_i,
  input  wire logic [7:0]  tx_seq_i,
  output var  logic        rx_frame_o,
  output var  logic        rx_is_ack_o,
  output var  logic        rx_ack_req_o,
  output var  logic [7:0]  rx_seq_o,
  output var  logic [79:0] rx_src_o,
  output var  logic        tx_done_o
);
  int   air_cyc  = 20;
  int   ack_mode = 0;
  int   starts   = 0;
  logic is_data;
  initial
  begin
    rx_frame_o   = 1'b0;
    rx_is_ack_o  = 1'b0;
    rx_ack_req_o = 1'b0;
    rx_seq_o     = 8'h0;
    rx_src_o     = 80'h0;
    tx_done_o    = 1'b0;
  end
  // One frame pulse; released lines invert so no stale value survives
  task automatic send(input logic a, input logic q, input logic [7:0] s,
                      input logic [79:0] src);
    @(posedge clk_i);
    rx_frame_o   <= 1'b1;
    rx_is_ack_o  <= a;
    rx_ack_req_o <= q;
    rx_seq_o     <= s;
    rx_src_o     <= src;
    @(posedge clk_i);
    rx_frame_o   <= 1'b0;
    rx_is_ack_o  <= ~a;
    rx_ack_req_o <= ~q;
    rx_seq_o     <= ~s;
    rx_src_o     <= ~src;
  endtask
  // Air time, done pulse, then an ACK matching or not as commanded
  always @(posedge clk_i)
    if (ack_start_i || frame_start_i)
    begin
      is_data = frame_start_i;
      starts  = starts + int'(frame_start_i);
      repeat (air_cyc) @(posedge clk_i);
      tx_done_o <= 1'b1;
      @(posedge clk_i);
      tx_done_o <= 1'b0;
      if (is_data && ack_mode != 0)
      begin
        repeat (10) @(posedge clk_i);
        send(1'b1, 1'b0, ack_mode == 1 ? tx_seq_i : ~tx_seq_i, ~rx_src_o);
      end
    end
endmodule
`default_nettype wire

// >>> tb_ack_handling_and_base_timer.sv
// Testbench for the ack handling and base timer core.
// Assumes the peer model and the bound port checker are compiled too.
`timescale 1ns/1ps
`default_nettype none
module tb_ack_handling_and_base_timer
  import ahbt_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m;} ahbt_exp_t;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, rdy, ack_st, frm_st, strm_to, off_done, bo_tick;
  logic        rx_frm, rx_ack, rx_req, tx_done;
  logic [7:0]  padr = 8'h0, tx_seq = 8'h0, rx_seq;
  logic [31:0] pwd = 32'h0, prd;
  logic [79:0] rx_src, src_a;
  int          errors = 0, checks_done = 0, n;
  ahbt_exp_t   note;
  ahbt_exp_t   exp_q[$];
  wire logic [3:0] evt = {bo_tick, off_done, strm_to, ack_st};
  // Recipient rows: control write, control read, flags, seq, request, ACK
  logic [7:0] c_wr [6] = '{8'h0E, 8'h00, 8'h00, 8'h00, 8'h0D, 8'h08};
  logic [7:0] c_rd [6] = '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0D, 8'h09};
  logic [7:0] flg  [6] = '{8'h46, 8'h16, 8'h08, 8'h10, 8'h08, 8'h40};
  logic [7:0] sq   [6] = '{8'h05, 8'h05, 8'h06, 8'h05, 8'h05, 8'h07};
  logic       req  [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic       ack  [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  ahbt_core ahbt_core_inst (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(), .RX_FRAME_I(rx_frm),
    .RX_IS_ACK_I(rx_ack), .RX_ACK_REQ_I(rx_req), .RX_SEQ_I(rx_seq),
    .RX_SRC_I(rx_src), .TX_SEQ_I(tx_seq), .TX_FRAME_DONE_I(tx_done),
    .TX_ACK_START_O(ack_st), .TX_FRAME_START_O(frm_st),
    .TX_CCA_BYPASS_O(), .BACKOFF_TICK_O(bo_tick), .STREAM_TO_O(strm_to),
    .OFF_TIME_DONE_O(off_done));
  ahbt_peer ahbt_peer_inst (
    .clk_i(clk), .ack_start_i(ack_st), .frame_start_i(frm_st),
    .tx_seq_i(tx_seq), .rx_frame_o(rx_frm), .rx_is_ack_o(rx_ack),
    .rx_ack_req_o(rx_req), .rx_seq_o(rx_seq), .rx_src_o(rx_src),
    .tx_done_o(tx_done));
  always #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One APB transfer; a read leaves its expected word in the queue
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m);
    if (!w)
      exp_q.push_back('{d, m});
    @(posedge clk);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // Cycles until an event pulse, or -1 if none within the limit
  task automatic wait_evt(input int k, input int lim, output int v);
    v = -1;
    for (int i = 0; i < lim && v < 0; i++)
    begin
      @(posedge clk);
      if (evt[k] === 1'b1)
        v = i;
    end
  endtask
  // Each completed read is matched against the oldest note
  always @(posedge clk)
    if (psel && pen && rdy === 1'b1 && !pwr && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check(prd & note.m, note.d & note.m);
    end
  initial
  begin
    void'($urandom(32'h516F5624));
    src_a = {16'($urandom), $urandom, $urandom};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, AHBT_TMR_CTRL_OFS, 32'h2, 32'hFFFFFFFF);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, 32'hFFFFFFFF);
    $display("Test reset done");
    apb(1'b1, AHBT_TMR_CTRL_OFS, 32'h1, 32'h0);
    apb(1'b1, AHBT_TIMERS_OFS, 32'h01000803, 32'h0);
    apb(1'b1, AHBT_TIMERS2_OFS, 32'h32, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      if (c_wr[i] != 8'h0)
        apb(1'b1, AHBT_RX_CTRL_OFS, {24'h0, c_wr[i]}, 32'h0);
      ahbt_peer_inst.send(1'b0, req[i], sq[i], src_a);
      wait_evt(0, 300, n);
      check({31'h0, n >= 0}, {31'h0, ack[i]});
      if (n >= 0)
        in_range(n, 80, 164);
      repeat (40) @(posedge clk);
      apb(1'b0, AHBT_RX_CTRL_OFS, {24'h0, c_rd[i]}, 32'hF);
      apb(1'b0, AHBT_FLAGS_OFS, {24'h0, flg[i]}, 32'hDF);
      apb(1'b1, AHBT_FLAGS_OFS, 32'hFF, 32'h0);
    end
    ahbt_peer_inst.send(1'b0, 1'b0, 8'h08, src_a);
    wait_evt(1, 3000, n);
    in_range(n, 1960, 2044);
    $display("Test recipient done");
    apb(1'b1, AHBT_RX_CTRL_OFS, 32'hC, 32'h0);
    apb(1'b1, AHBT_RETRY_OFS, 32'h1, 32'h0);
    apb(1'b1, AHBT_FLAGS_OFS, 32'hFF, 32'h0);
    ahbt_peer_inst.air_cyc = 60;
    ahbt_peer_inst.ack_mode = 1;
    tx_seq <= 8'($urandom);
    apb(1'b1, AHBT_CMD_OFS, 32'h1, 32'h0);
    wait_evt(2, 3000, n);
    in_range(n, 1240, 1700);
    apb(1'b0, AHBT_FLAGS_OFS, 32'h21, 32'hF9);
    apb(1'b1, AHBT_FLAGS_OFS, 32'hFF, 32'h0);
    ahbt_peer_inst.ack_mode = 2;
    tx_seq <= 8'($urandom);
    apb(1'b1, AHBT_CMD_OFS, 32'h1, 32'h0);
    for (int i = 0; i < 3000 && ahbt_peer_inst.starts < 3; i++)
      @(posedge clk);
    repeat (500) @(posedge clk);
    check(32'(ahbt_peer_inst.starts), 32'h3);
    apb(1'b0, AHBT_FLAGS_OFS, 32'h80, 32'hF9);
    $display("Test originator done");
    apb(1'b1, AHBT_RX_CTRL_OFS, 32'h0, 32'h0);
    // Without auto ack a data frame ends with tx done at once
    apb(1'b1, AHBT_CMD_OFS, 32'h1, 32'h0);
    repeat (100) @(posedge clk);
    apb(1'b0, AHBT_FLAGS_OFS, 32'h81, 32'hF9);
    apb(1'b1, AHBT_TMR_CTRL_OFS, 32'h2, 32'h0);
    apb(1'b1, AHBT_TIMERS_OFS, 32'h01A00803, 32'h0);
    wait_evt(3, 26000, n);
    wait_evt(3, 26000, n);
    in_range(n, 12797, 12881);
    $display("Test backoff done");
    test_done();
  end
  // Run needs about 32000 cycles, mostly two backoff periods
  initial
  begin
    repeat (70000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
